// File: shared/gmps_cfg.svh
// gmps_cfg.svh: offsets, field positions, codes and timing counts
// assumes inclusion by bare name from the package and the sim files
`ifndef GMPS_CFG_SVH
`define GMPS_CFG_SVH
`define GMPS_REG_PROFILE      12'h000
`define GMPS_REG_COMMAND      12'h004
`define GMPS_REG_TRAVEL_SPD   12'h008
`define GMPS_REG_GRIP_FORCE   12'h00C
`define GMPS_REG_OPEN_POS     12'h010
`define GMPS_REG_CLOSED_POS   12'h014
`define GMPS_REG_EXPECT_POS   12'h018
`define GMPS_REG_CHANGE_POS   12'h01C
`define GMPS_REG_WINDOW       12'h020
`define GMPS_REG_HANDSHAKE    12'h024
`define GMPS_REG_STATUS       12'h028
`define GMPS_REG_POSITION     12'h02C
`define GMPS_REG_SPEED        12'h030
`define GMPS_CMD_OPEN         16'h0100
`define GMPS_CMD_CLOSE        16'h0200
`define GMPS_ST_BUSY          0
`define GMPS_ST_AT_OPEN       1
`define GMPS_ST_AT_CLOSED     2
`define GMPS_ST_GRIPPED       3
`define GMPS_ST_LOCKED        4
`define GMPS_ST_EXPECT        5
`define GMPS_ST_PART_LOST     6
`define GMPS_ST_BAD_PROFILE   7
`define GMPS_ST_BLOCKED       8
`define GMPS_ST_ENERGIZED     9
`define GMPS_ST_FORCE_MODE    10
`define GMPS_UNLOCK_TIME_US   100
`define GMPS_CLK_MHZ          25
`define GMPS_UNLOCK_CYC       (`GMPS_UNLOCK_TIME_US * `GMPS_CLK_MHZ)
`define GMPS_STEP_DIV         25
`define GMPS_OVERSHOOT        16'h0020
`define GMPS_SLOW_DIV         2
`define GMPS_HOLD_NORMAL      8'h40
`define GMPS_HOLD_STRONG      8'h80
`endif

// File: shared/gmps_pkg.sv
// gmps_pkg: types shared by the sequencer and its stepper
// assumes gmps_cfg.svh is on the include path
package gmps_pkg;
`include "gmps_cfg.svh"
   typedef enum logic [3:0] {
      GMPS_IDLE    = 4'h0,
      GMPS_UNLOCK  = 4'h1,
      GMPS_POS     = 4'h2,
      GMPS_FORCE   = 4'h3,
      GMPS_BUILD   = 4'h4,
      GMPS_HOLD    = 4'h5,
      GMPS_OVER    = 4'h6,
      GMPS_BACK    = 4'h7,
      GMPS_HALT    = 4'h8
   } gmps_state_t;
   typedef struct packed {
      logic        valid;
      logic        grip;
      logic        inward;
      logic        skip_unlock;
      logic        hold_on;
      logic        slow;
      logic [7:0]  hold_cur;
   } gmps_prof_t;
   typedef struct packed {
      logic        step;
      logic        dir_up;
   } gmps_move_t;
endpackage : gmps_pkg

// File: rtl/gmps_stepper.sv
// gmps_stepper: position counter advanced by a divided step enable
// assumes a single pclk domain; speed 0 means stopped
module gmps_stepper
   import gmps_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        run,
   input  wire logic        dir_up,
   input  wire logic [7:0]  speed,
   output logic      [15:0] position
);
   logic [15:0] acc_q;
   // step rate grows with speed; divider keeps one clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q    <= 16'h0000;
         position <= 16'h0000;
      end else if (run && speed != 8'h00) begin
         if (acc_q + {8'h00, speed} >= 16'(`GMPS_STEP_DIV * 4)) begin
            acc_q <= 16'h0000;
            if (dir_up)
               position <= position + 16'h0001;
            else if (position != 16'h0000)
               position <= position - 16'h0001;
         end else begin
            acc_q <= acc_q + {8'h00, speed};
         end
      end
   end
endmodule : gmps_stepper

// File: rtl/gmps_sequencer.sv
// gmps_sequencer: gripper jaw motion profile sequencer, APB slave
// assumes motor current sense and obstacle flag as async pins
//
// Behaviour
// - decode profile code into families 5x..9x and their sub-variants
// - positioning moves to open or closed end on command, travel speed
// - positioning ignores expected and changeover positions
// - positioning halts at obstacle, reversed command returns
// - profile 51 equals 50 without initial unlock
// - outward 0x0200 force-drives toward closed end until part or end
// - outward 0x0100 opens to open end in position mode
// - no part: brake, overshoot closed end, reverse, stop there
// - grip locks; release unlocks at travel speed then position mode
// - grip speed derived from grip force setting
// - profile 60 unlocks, detects current rise, builds force, de-energizes
// - profile 60 does not follow a slipped part, no loss flag
// - profile 61 equals 60 without unlock; controller keeps jaws unloaded
// - profile 63 holds energized, sets expected flag, loss runs to end
// - profile 64 is 63 with higher holding current
// - profile 65 is 60 but slower, force mostly from current
// - inward group swaps open and closed end roles
// - pre-positioned sub-codes 84/94 strong, 85/95 normal holding
// - inward 0x0100 grips toward open end, 0x0200 opens to closed
module gmps_sequencer
   import gmps_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        current_rise_pin,
   input  wire logic        obstacle_pin,
   output logic             motor_run,
   output logic             motor_dir_up,
   output logic      [7:0]  motor_current,
   output logic             lock_engaged
);
   logic [7:0]  profile_code_q, profile_new_q;
   logic [15:0] command_word_q;
   logic [7:0]  travel_speed_setting_q, grip_force_setting_q;
   logic [15:0] open_end_position_q, closed_end_position_q;
   logic [15:0] expected_part_position_q, changeover_position_q;
   logic [15:0] part_position_window_q;
   logic        bad_profile_q, expect_q, lost_q, gripped_q, blocked_q;
   gmps_state_t state_q;
   gmps_prof_t  prof;
   logic [1:0]  cur_sync_q, obs_sync_q;
   logic        cur_rise, obstacle;
   logic [15:0] position, target_q, over_q;
   logic [7:0]  speed_q, derived_grip_speed;
   logic        dir_q, run_q, force_mode;
   logic [15:0] unlock_cnt_q;
   logic [15:0] cmd_prev_q;
   logic        apb_wr, apb_rd;

   // decoder is a function so the handshake check and the run share it
   function automatic gmps_prof_t decode(input logic [7:0] code);
      gmps_prof_t p;
      logic [3:0] grp, sub;
      p   = '0;
      grp = code > 8'd99 ? 4'hF : 4'(code / 8'd10);
      sub = 4'(code % 8'd10);
      p.hold_cur = `GMPS_HOLD_NORMAL;
      unique case (grp)
         4'h5: p.valid = (sub <= 4'h1);
         4'h6, 4'h7: p.valid = (sub <= 4'h1) || (sub >= 4'h3 && sub <= 4'h5);
         4'h8, 4'h9: p.valid = (sub <= 4'h1) || sub == 4'h4 || sub == 4'h5;
         default: p.valid = 1'b0;
      endcase
      p.grip        = (grp >= 4'h6);
      p.inward      = (grp == 4'h7) || (grp == 4'h9);
      p.skip_unlock = (sub == 4'h1);
      p.slow        = (grp <= 4'h7) && (sub == 4'h5);
      if (grp <= 4'h7) begin
         p.hold_on = (sub == 4'h3) || (sub == 4'h4);
         if (sub == 4'h4)
            p.hold_cur = `GMPS_HOLD_STRONG;
      end else begin
         p.hold_on = (sub == 4'h4) || (sub == 4'h5);
         if (sub == 4'h4)
            p.hold_cur = `GMPS_HOLD_STRONG;
      end
      return p;
   endfunction : decode

   assign prof = decode(profile_code_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_sync_q <= 2'b00;
         obs_sync_q <= 2'b00;
      end else begin
         cur_sync_q <= {cur_sync_q[0], current_rise_pin};
         obs_sync_q <= {obs_sync_q[0], obstacle_pin};
      end
   end
   assign cur_rise = cur_sync_q[1];
   assign obstacle = obs_sync_q[1];

   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && !penable && !pwrite;

   // zero-wait slave: pready always high once out of reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         profile_new_q            <= 8'h00;
         command_word_q           <= 16'h0000;
         travel_speed_setting_q   <= 8'h32;
         grip_force_setting_q     <= 8'h32;
         open_end_position_q      <= 16'h0000;
         closed_end_position_q    <= 16'h0FA0;
         expected_part_position_q <= 16'h0000;
         changeover_position_q    <= 16'h0000;
         part_position_window_q   <= 16'h0032;
      end else if (apb_wr) begin
         unique case (paddr)
            `GMPS_REG_PROFILE:    profile_new_q <= pwdata[7:0];
            `GMPS_REG_COMMAND:    command_word_q <= pwdata[15:0];
            `GMPS_REG_TRAVEL_SPD: travel_speed_setting_q <= pwdata[7:0];
            `GMPS_REG_GRIP_FORCE: grip_force_setting_q <= pwdata[7:0];
            `GMPS_REG_OPEN_POS:   open_end_position_q <= pwdata[15:0];
            `GMPS_REG_CLOSED_POS: closed_end_position_q <= pwdata[15:0];
            `GMPS_REG_EXPECT_POS: expected_part_position_q <= pwdata[15:0];
            `GMPS_REG_CHANGE_POS: changeover_position_q <= pwdata[15:0];
            `GMPS_REG_WINDOW:     part_position_window_q <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // profile takes effect only through the handshake write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         profile_code_q <= 8'h00;
         bad_profile_q  <= 1'b1;
      end else if (apb_wr && paddr == `GMPS_REG_HANDSHAKE &&
                   pwdata[0]) begin
         profile_code_q <= profile_new_q;
         bad_profile_q  <= !decode(profile_new_q).valid;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (apb_rd) begin
            unique case (paddr)
               `GMPS_REG_PROFILE:    prdata <= {24'h0, profile_code_q};
               `GMPS_REG_COMMAND:    prdata <= {16'h0, command_word_q};
               `GMPS_REG_TRAVEL_SPD: prdata <= {24'h0, travel_speed_setting_q};
               `GMPS_REG_GRIP_FORCE: prdata <= {24'h0, grip_force_setting_q};
               `GMPS_REG_OPEN_POS:   prdata <= {16'h0, open_end_position_q};
               `GMPS_REG_CLOSED_POS: prdata <= {16'h0, closed_end_position_q};
               `GMPS_REG_EXPECT_POS: prdata <= {16'h0,
                                                expected_part_position_q};
               `GMPS_REG_CHANGE_POS: prdata <= {16'h0, changeover_position_q};
               `GMPS_REG_WINDOW:     prdata <= {16'h0, part_position_window_q};
               `GMPS_REG_HANDSHAKE:  prdata <= 32'h0000_0000;
               `GMPS_REG_STATUS:     prdata <= {21'h0, force_mode,
                  prof.hold_on && state_q == GMPS_HOLD, blocked_q,
                  bad_profile_q, lost_q, expect_q, lock_engaged, gripped_q,
                  position == target_q && state_q == GMPS_IDLE,
                  position == open_end_position_q, state_q != GMPS_IDLE};
               `GMPS_REG_POSITION:   prdata <= {16'h0, position};
               `GMPS_REG_SPEED:      prdata <= {24'h0, speed_q};
               default:              pslverr <= 1'b1;
            endcase
         end else if (paddr > `GMPS_REG_SPEED || paddr[1:0] != 2'b00) begin
            pslverr <= 1'b1;
         end
      end
   end

   // force comes from speed and current; slow profile halves the speed
   always_comb begin
      derived_grip_speed = grip_force_setting_q;
      if (prof.slow)
         derived_grip_speed = grip_force_setting_q >> 1;
   end
   assign force_mode = (state_q == GMPS_FORCE) || (state_q == GMPS_BUILD);

   gmps_stepper u_step (
      .pclk     (pclk),
      .presetn  (presetn),
      .run      (run_q && (position != target_q || state_q == GMPS_OVER)),
      .dir_up   (dir_q),
      .speed    (speed_q),
      .position (position)
   );

   // the grip command is 0x0200 outward, 0x0100 inward
   logic cmd_grip, cmd_open, cmd_new;
   logic [15:0] grip_end, rel_end;
   assign cmd_new  = command_word_q != cmd_prev_q;
   assign cmd_grip = prof.inward ? command_word_q == `GMPS_CMD_OPEN
                                 : command_word_q == `GMPS_CMD_CLOSE;
   assign cmd_open = prof.inward ? command_word_q == `GMPS_CMD_CLOSE
                                 : command_word_q == `GMPS_CMD_OPEN;
   assign grip_end = prof.inward ? open_end_position_q
                                 : closed_end_position_q;
   assign rel_end  = prof.inward ? closed_end_position_q
                                 : open_end_position_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q      <= GMPS_IDLE;
         target_q     <= 16'h0000;
         over_q       <= 16'h0000;
         speed_q      <= 8'h00;
         dir_q        <= 1'b0;
         run_q        <= 1'b0;
         unlock_cnt_q <= 16'h0000;
         cmd_prev_q   <= 16'h0000;
         gripped_q    <= 1'b0;
         expect_q     <= 1'b0;
         lost_q       <= 1'b0;
         blocked_q    <= 1'b0;
         lock_engaged <= 1'b0;
      end else begin
         cmd_prev_q <= command_word_q;
         unique case (state_q)
            GMPS_IDLE, GMPS_HALT, GMPS_HOLD: begin
               if (state_q == GMPS_HOLD && prof.hold_on &&
                   !cur_rise && position != grip_end) begin
                  // part slipped: energized jaws follow to the end
                  state_q <= GMPS_POS;
                  target_q <= grip_end;
                  dir_q    <= grip_end > position;
                  speed_q  <= derived_grip_speed;
                  run_q    <= 1'b1;
                  expect_q <= 1'b0;
                  lost_q   <= 1'b1;
               end else if (cmd_new && !bad_profile_q &&
                            (cmd_grip || cmd_open)) begin
                  lost_q    <= 1'b0;
                  blocked_q <= 1'b0;
                  expect_q  <= 1'b0;
                  gripped_q <= 1'b0;
                  // positioning targets ends only
                  target_q  <= prof.grip ? (cmd_grip ? grip_end : rel_end)
                     : (command_word_q == `GMPS_CMD_CLOSE ?
                        closed_end_position_q : open_end_position_q);
                  if (!prof.skip_unlock && lock_engaged) begin
                     state_q      <= GMPS_UNLOCK;
                     unlock_cnt_q <= 16'(`GMPS_UNLOCK_CYC);
                     speed_q      <= travel_speed_setting_q;
                     dir_q        <= !(grip_end > rel_end);
                     run_q        <= 1'b1;
                  end else begin
                     state_q <= (prof.grip && cmd_grip) ? GMPS_FORCE
                                                        : GMPS_POS;
                     run_q   <= 1'b0;
                  end
                  lock_engaged <= 1'b0;
               end else if (state_q == GMPS_HOLD && !prof.hold_on) begin
                  run_q <= 1'b0;
               end
            end
            GMPS_UNLOCK: begin
               if (unlock_cnt_q == 16'h0001) begin
                  run_q   <= 1'b0;
                  state_q <= (prof.grip && cmd_grip) ? GMPS_FORCE : GMPS_POS;
               end
               unlock_cnt_q <= unlock_cnt_q - 16'h0001;
            end
            GMPS_POS: begin
               speed_q <= travel_speed_setting_q;
               dir_q   <= target_q > position;
               run_q   <= position != target_q;
               if (!prof.grip && obstacle) begin
                  run_q     <= 1'b0;
                  blocked_q <= 1'b1;
                  state_q   <= GMPS_HALT;
               end else if (position == target_q) begin
                  run_q   <= 1'b0;
                  state_q <= GMPS_IDLE;
               end
            end
            GMPS_FORCE: begin
               speed_q <= derived_grip_speed;
               dir_q   <= target_q > position;
               run_q   <= 1'b1;
               if (cur_rise) begin
                  state_q <= GMPS_BUILD;
               end else if (position == target_q) begin
                  // no part: run past the end, then come back
                  over_q  <= dir_q ? target_q + `GMPS_OVERSHOOT
                                   : target_q - `GMPS_OVERSHOOT;
                  state_q <= GMPS_OVER;
               end
            end
            GMPS_BUILD: begin
               run_q        <= 1'b0;
               gripped_q    <= 1'b1;
               lock_engaged <= 1'b1;
               expect_q     <= prof.hold_on;
               state_q      <= GMPS_HOLD;
            end
            GMPS_OVER: begin
               dir_q   <= over_q > position;
               if (position == over_q) begin
                  dir_q   <= !dir_q;
                  state_q <= GMPS_BACK;
               end
            end
            GMPS_BACK: begin
               if (position == target_q) begin
                  run_q   <= 1'b0;
                  state_q <= GMPS_IDLE;
               end
            end
            default: state_q <= GMPS_IDLE;
         endcase
      end
   end

   // outputs registered; holding current only in energized hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motor_run     <= 1'b0;
         motor_dir_up  <= 1'b0;
         motor_current <= 8'h00;
      end else begin
         motor_run    <= run_q;
         motor_dir_up <= dir_q;
         if (state_q == GMPS_HOLD && prof.hold_on)
            motor_current <= prof.hold_cur;
         else if (run_q)
            motor_current <= prof.slow ? `GMPS_HOLD_STRONG : speed_q;
         else
            motor_current <= 8'h00;
      end
   end
endmodule : gmps_sequencer

// File: sim/gmps_sequencer_chk.sv
// gmps_sequencer_chk: port assertions for the jaw sequencer
// assumes one pclk domain and the apb offsets of gmps_cfg.svh
`include "gmps_cfg.svh"
module gmps_sequencer_chk
   import gmps_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        current_rise_pin,
   input wire logic        obstacle_pin,
   input wire logic        motor_run,
   input wire logic        motor_dir_up,
   input wire logic [7:0]  motor_current,
   input wire logic        lock_engaged
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0]  prof_q;
   logic [7:0]  act_q;
   logic [15:0] last_q;
   logic        fresh_q;
   logic        wr;
   logic        cmd_wr;
   logic        ok;
   assign wr = psel && penable && pwrite && pready;
   // a repeated command is not a new request, so only changes count
   assign cmd_wr = wr && paddr == `GMPS_REG_COMMAND
                   && pwdata[15:0] != 16'h0000 && pwdata[15:0] != last_q;
   assign ok = act_q inside {8'h32, 8'h33, 8'h3C, 8'h3D, 8'h3F, 8'h40,
      8'h41, 8'h46, 8'h47, 8'h49, 8'h4A, 8'h4B, 8'h50, 8'h51, 8'h54,
      8'h55, 8'h5A, 8'h5B, 8'h5E, 8'h5F};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prof_q  <= 8'h00;
         act_q   <= 8'h00;
         last_q  <= 16'h0000;
         fresh_q <= 1'b0;
      end else begin
         if (wr && paddr == `GMPS_REG_PROFILE) prof_q <= pwdata[7:0];
         if (wr && paddr == `GMPS_REG_HANDSHAKE && pwdata[0]) act_q <= prof_q;
         if (cmd_wr) last_q <= pwdata[15:0];
         fresh_q <= cmd_wr || (fresh_q && !motor_run);
      end
   end
   chk_ready_high: assert property ($past(presetn) |-> pready)
      else $error("pready low outside reset");
   chk_err_unmapped: assert property (psel && penable &&
      (paddr > 12'h030 || paddr[1:0] != 2'b00) |-> pslverr)
      else $error("no error on unmapped address");
   chk_err_mapped: assert property (psel && penable &&
      paddr <= 12'h030 && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("error on mapped address");
   chk_reset_quiet: assert property ($rose(presetn) |->
      !motor_run && !lock_engaged && motor_current == 8'h00)
      else $error("motor active after reset");
   chk_bad_idle: assert property (!ok && !motor_run |=> !motor_run)
      else $error("motion on undefined profile");
   chk_fast_start: assert property (cmd_wr && act_q == 8'h33
      && !motor_run |-> ##[1:8] motor_run)
      else $error("profile 51 slow to start");
   chk_first_dir: assert property ($rose(motor_run) && fresh_q
      && !lock_engaged && !$past(lock_engaged) && act_q inside {[8'h32:8'h4B]}
      |-> motor_dir_up == (last_q == `GMPS_CMD_CLOSE))
      else $error("wrong direction for command");
   chk_obstacle_halt: assert property ((obstacle_pin
      && act_q inside {8'h32, 8'h33})[*6] |-> !motor_run)
      else $error("no halt at obstacle");
   cover property ($rose(lock_engaged));
   cover property (cmd_wr && act_q == 8'h49);
   cover property ($fell(motor_run) && obstacle_pin);
endmodule : gmps_sequencer_chk

bind gmps_sequencer gmps_sequencer_chk i_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .current_rise_pin(current_rise_pin), .obstacle_pin(obstacle_pin),
   .motor_run(motor_run), .motor_dir_up(motor_dir_up),
   .motor_current(motor_current), .lock_engaged(lock_engaged));

// File: sim/gmps_jaw_model.sv
// gmps_jaw_model: jaws, part and obstacle seen through the sense pins
// assumes contact shows after a fixed run time once a part is placed
module gmps_jaw_model #(
   parameter int CONTACT_CYC = 20
)
(
   input  wire logic pclk,
   input  wire logic motor_run,
   input  wire logic part_en,
   input  wire logic block_en,
   output logic      current_rise_pin,
   output logic      obstacle_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   int run_cnt = 0;
   // jaws start unloaded until a part is placed
   always @(posedge pclk) begin
      if (!part_en) run_cnt <= 0;
      else if (motor_run && run_cnt < CONTACT_CYC) run_cnt <= run_cnt + 1;
   end
   // current stays raised only while the part is clamped
   assign current_rise_pin = part_en && run_cnt >= CONTACT_CYC;
   assign obstacle_pin     = block_en;
endmodule : gmps_jaw_model

// File: sim/gmps_sequencer_tb.sv
// gmps_sequencer_tb: apb-driven profile tests for the jaw sequencer
// assumes a zero-wait apb slave and the jaw model on the sense pins
`include "gmps_cfg.svh"
module gmps_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        motor_run, motor_dir_up, lock_engaged, rise, obst;
   logic        part_en, block_en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d, sp, top, pos;
   logic [7:0]  motor_current;
   logic [7:0]  cur [5];
   logic [31:0] spd [5];
   logic [7:0]  codes [28] = '{8'h32, 8'h33, 8'h3C, 8'h3D, 8'h3F, 8'h40,
      8'h41, 8'h46, 8'h47, 8'h49, 8'h4A, 8'h4B, 8'h50, 8'h51, 8'h54, 8'h55,
      8'h5A, 8'h5B, 8'h5E, 8'h5F, 8'h34, 8'h3E, 8'h42, 8'h48, 8'h52, 8'h56,
      8'h60, 8'h31};
   logic [7:0]  fp [5] = '{8'h3C, 8'h3D, 8'h3F, 8'h40, 8'h41};
   logic [4:0]  en = 5'b01100;
   int          n_errors = 0;
   int          n_checks = 0;
   int          cyc = 0;
   gmps_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .current_rise_pin(rise), .obstacle_pin(obst), .motor_run(motor_run),
      .motor_dir_up(motor_dir_up), .motor_current(motor_current),
      .lock_engaged(lock_engaged));
   gmps_jaw_model i_jaw (.pclk(pclk), .motor_run(motor_run),
      .part_en(part_en), .block_en(block_en), .current_rise_pin(rise),
      .obstacle_pin(obst));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_errors++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // request held until pready is seen; one idle edge keeps drives apart
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] v);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic start(input logic [7:0] p);
      presetn <= 1'b0;
      part_en <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      apb(1'b1, `GMPS_REG_CLOSED_POS, 32'h0000_0040);
      apb(1'b1, `GMPS_REG_TRAVEL_SPD, 32'h0000_0064);
      apb(1'b1, `GMPS_REG_GRIP_FORCE, 32'h0000_0064);
      apb(1'b1, `GMPS_REG_PROFILE, {24'h0, p});
      apb(1'b1, `GMPS_REG_HANDSHAKE, 32'h0000_0001);
   endtask : start
   // polls until idle or gripped, noting the top position
   task automatic move(input logic [15:0] c);
      apb(1'b1, `GMPS_REG_COMMAND, 32'h0);
      apb(1'b1, `GMPS_REG_COMMAND, {16'h0, c});
      repeat (8) @(posedge pclk);
      apb(1'b0, `GMPS_REG_SPEED, 32'h0);
      sp = d;
      top = 32'h0;
      do begin
         apb(1'b0, `GMPS_REG_POSITION, 32'h0);
         if (d > top) top = d;
         apb(1'b0, `GMPS_REG_STATUS, 32'h0);
      end while (d[`GMPS_ST_BUSY] === 1'b1 && !d[`GMPS_ST_GRIPPED]);
      apb(1'b0, `GMPS_REG_POSITION, 32'h0);
      pos = d;
      apb(1'b0, `GMPS_REG_STATUS, 32'h0);
   endtask : move
   initial begin
      {presetn, psel, penable, pwrite, part_en, block_en} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      @(posedge pclk);
      start(8'h3E);
      apb(1'b0, 12'h040, 32'h0);
      chk(err ? d : 32'hFFFF_FFFF, 32'h0);
      move(`GMPS_CMD_CLOSE);
      chk(32'(d[`GMPS_ST_BAD_PROFILE]), 32'h1);
      chk(top, 32'h0);
      for (int i = 0; i < 28; i++) begin
         apb(1'b1, `GMPS_REG_PROFILE, {24'h0, codes[i]});
         apb(1'b1, `GMPS_REG_HANDSHAKE, 32'h1);
         apb(1'b0, `GMPS_REG_STATUS, 32'h0);
         chk(32'(d[`GMPS_ST_BAD_PROFILE]), 32'(i >= 20));
      end
      $display("code decode test done");
      start(8'h32);
      apb(1'b1, `GMPS_REG_EXPECT_POS, 32'h0000_0010);
      apb(1'b1, `GMPS_REG_CHANGE_POS, 32'h0000_0008);
      move(`GMPS_CMD_CLOSE);
      chk(pos, 32'h40);
      move(`GMPS_CMD_OPEN);
      chk(pos, 32'h0);
      start(8'h33);
      apb(1'b1, `GMPS_REG_COMMAND, {16'h0, `GMPS_CMD_CLOSE});
      repeat (10) @(posedge pclk);
      block_en <= 1'b1;
      repeat (8) @(posedge pclk);
      apb(1'b0, `GMPS_REG_STATUS, 32'h0);
      chk(32'(d[`GMPS_ST_BLOCKED]), 32'h1);
      block_en <= 1'b0;
      move(`GMPS_CMD_OPEN);
      chk(pos, 32'h0);
      $display("positioning test done");
      for (int i = 0; i < 5; i++) begin
         start(fp[i]);
         part_en <= 1'b1;
         move(`GMPS_CMD_CLOSE);
         chk(32'(d[4:3]), 32'h3);
         chk(32'(d[`GMPS_ST_ENERGIZED]), 32'(en[i]));
         chk(32'(d[`GMPS_ST_EXPECT]), 32'(en[i]));
         chk(32'(pos < 32'h40), 32'h1);
         cur[i] = motor_current;
         spd[i] = sp;
         part_en <= 1'b0;
         repeat (400) @(posedge pclk);
         apb(1'b0, `GMPS_REG_STATUS, 32'h0);
         chk(32'(d[`GMPS_ST_PART_LOST]), 32'(en[i]));
         apb(1'b0, `GMPS_REG_POSITION, 32'h0);
         chk(32'(d == 32'h40), 32'(en[i]));
      end
      chk(32'(cur[3] > cur[2]), 32'h1);
      chk(spd[4], spd[0] >> 1);
      $display("force profile test done");
      start(8'h3F); // outward profile 63, energized hold
      move(`GMPS_CMD_CLOSE);
      chk(32'(top > 32'h40), 32'h1);
      chk(pos, 32'h40);
      start(8'h49);
      move(`GMPS_CMD_CLOSE);
      chk(pos, 32'h40);
      part_en <= 1'b1;
      move(`GMPS_CMD_OPEN);
      chk(32'(d[`GMPS_ST_GRIPPED]), 32'h1);
      chk(32'(pos < 32'h40 && pos > 32'h0), 32'h1);
      $display("overshoot and inward test done");
      conclude();
   end
endmodule : gmps_sequencer_tb
